// [cfg_loader_consts.vh]
// constants for the parallel peripheral configuration loader
`ifndef CFG_LOADER_CONSTS_VH
`define CFG_LOADER_CONSTS_VH

// mode pin patterns, high-to-low order
`define MODE_SYNC_PERIPH 3'h3
`define MODE_ASYNC_PERIPH 3'h5

// byte framing
`define BYTE_WIDTH 8
`define BYTE_EDGE_LAST 3'h7
`define BITS_PER_BYTE 4'h8

// busy interval bounds in configuration clock periods
`define BUSY_MIN_TICKS 4'h2
`define BUSY_MAX_TICKS 4'h9

// chained output idles high
`define CHAIN_IDLE 1'h1

// system clock period and internal clock divider
`define SYS_CLK_PERIOD_NS 100
`define INT_CONFIG_CLOCK_PERIOD_NS 800
`define INT_CONFIG_CLOCK_DIV (`INT_CONFIG_CLOCK_PERIOD_NS / `SYS_CLK_PERIOD_NS)

`endif

// [cfg_serializer.v]
// double-buffered parallel-to-serial converter with chained output
`timescale 1ns/1ps
module cfg_serializer #(
   parameter PREAMBLE_BITS = 40,
   parameter OWN_BITS = 64,
   parameter COUNT_W = 20
) (
   // clock and reset
   input wire clk,
   input wire srst,
   // byte load
   input wire load,
   input wire [7:0] load_byte,
   // shift timing
   input wire shift_tick,
   input wire fall_tick,
   // status and output
   output reg hold_full,
   output wire shift_busy,
   output reg serial_out
);
`include "cfg_loader_consts.vh"

   reg [7:0] hold;
   reg [7:0] shreg;
   reg [3:0] bits_left;
   reg [COUNT_W-1:0] bit_count;
   reg stage_bit;
   reg stage_pass;
   reg stage_valid;
   wire passes;

   assign shift_busy = (bits_left != 4'h0);
   // preamble goes through, own bits are kept, everything beyond overflows
   assign passes = (bit_count < PREAMBLE_BITS) || (bit_count >= PREAMBLE_BITS + OWN_BITS);

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (srst) begin
         hold <= 8'h00;
         hold_full <= 1'b0;
         shreg <= 8'h00;
         bits_left <= 4'h0;
         bit_count <= {COUNT_W{1'b0}};
         stage_bit <= `CHAIN_IDLE;
         stage_pass <= 1'b0;
         stage_valid <= 1'b0;
         serial_out <= `CHAIN_IDLE;
      end else begin
         if (load) begin
            hold <= load_byte;
            hold_full <= 1'b1;
         end else if (hold_full && !shift_busy) begin
            // second-level buffer empty: move the byte down
            shreg <= hold;
            bits_left <= `BITS_PER_BYTE;
            hold_full <= 1'b0;
         end
         if (shift_tick && shift_busy) begin
            stage_bit <= shreg[0];
            stage_pass <= passes;
            stage_valid <= 1'b1;
            shreg <= {1'b0, shreg[7:1]};
            bits_left <= bits_left - 4'h1;
            if (bit_count != {COUNT_W{1'b1}}) begin
               bit_count <= bit_count + {{(COUNT_W-1){1'b0}}, 1'b1};
            end
         end else if (shift_tick) begin
            stage_valid <= 1'b0;
         end
         if (fall_tick) begin
            serial_out <= (stage_valid && stage_pass) ? stage_bit : `CHAIN_IDLE;
         end
      end
   end

endmodule

// [cfg_loader.v]
// parallel peripheral configuration loader, device side
// Function
// - mode pins 011, high to low, select synchronous peripheral mode
// - after first byte, a byte is captured every eighth rising edge
// - capture edge raises handshake for exactly one configuration clock period
// - handshake is not driven, only pulled up, until init goes high
// - preamble and overflow bits go out on the chained serial output
// - chained output lags by 1.5 periods, changing on falling edge
// - asynchronous writes hold handshake low 2 to 9 periods while busy
// - busy shortest into empty converter, longest when both buffers full
// - asynchronous byte is taken at the trailing strobe edge at latest
// - processing delay depends on prior byte and internal clock phase
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"
module cfg_loader #(
   parameter PREAMBLE_BITS = 40,
   parameter OWN_BITS = 64,
   parameter COUNT_W = 20,
   parameter CONFIG_CLOCK_DIV = `INT_CONFIG_CLOCK_DIV
) (
   // system clock and reset
   input wire CLK,
   input wire SRST,
   // configuration clock from the controller
   input wire CONFIG_CLOCK,
   // mode pins
   input wire MODE_SELECT_HIGH,
   input wire MODE_SELECT_MID,
   input wire MODE_SELECT_LOW,
   // initialization pin level
   input wire INIT,
   // parallel data and write strobe
   input wire [7:0] DATA,
   input wire WRITE_STROBE_N,
   // handshake pin
   output reg READY_BUSY_OUT,
   output reg READY_BUSY_OE,
   // chained serial output
   output wire CHAIN_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   reg [1:0] config_clock_sync;
   reg config_clock_last;
   reg [1:0] init_sync;
   reg [1:0] strobe_sync;
   reg strobe_last;
   reg [2:0] mode_meta;
   reg [2:0] mode_sync;
   wire [7:0] data_sync;

   always @(posedge CLK) begin
      if (SRST) begin
         config_clock_sync <= 2'h0;
         config_clock_last <= 1'b0;
         init_sync <= 2'h0;
         strobe_sync <= 2'h3;
         strobe_last <= 1'b1;
         mode_meta <= 3'h0;
         mode_sync <= 3'h0;
      end else begin
         config_clock_sync <= {config_clock_sync[0], CONFIG_CLOCK};
         config_clock_last <= config_clock_sync[1];
         init_sync <= {init_sync[0], INIT};
         strobe_sync <= {strobe_sync[0], WRITE_STROBE_N};
         strobe_last <= strobe_sync[1];
         mode_meta <= {MODE_SELECT_HIGH, MODE_SELECT_MID, MODE_SELECT_LOW};
         mode_sync <= mode_meta;
      end
   end

   // one two-flop chain per data bit, in step with the strobe and clock chains
   genvar g;
   generate
      for (g = 0; g < `BYTE_WIDTH; g = g + 1) begin : data_bit
         reg [1:0] stage;
         always @(posedge CLK) begin
            if (SRST) begin
               stage <= 2'h0;
            end else begin
               stage <= {stage[0], DATA[g]};
            end
         end
         assign data_sync[g] = stage[1];
      end
   endgenerate

   // edge finder shared by the clock and strobe chains
   function edge_seen;
      input level;
      input prev;
      input rising;
      begin
         edge_seen = rising ? (level && !prev) : (!level && prev);
      end
   endfunction

   // mode pins against one pattern
   function mode_match;
      input [2:0] pins;
      input [2:0] code;
      begin
         mode_match = (pins == code);
      end
   endfunction

   wire init_high;
   wire config_clock_rise;
   wire config_clock_fall;
   wire strobe_rise;
   wire strobe_fall;
   wire sync_mode;
   wire async_mode;

   assign init_high = init_sync[1];
   // the controller supplies this clock, the device only samples it
   assign config_clock_rise = edge_seen(config_clock_sync[1], config_clock_last, 1'b1);
   assign config_clock_fall = edge_seen(config_clock_sync[1], config_clock_last, 1'b0);
   assign strobe_rise = edge_seen(strobe_sync[1], strobe_last, 1'b1);
   assign strobe_fall = edge_seen(strobe_sync[1], strobe_last, 1'b0);
   assign sync_mode = mode_match(mode_sync, `MODE_SYNC_PERIPH);
   assign async_mode = mode_match(mode_sync, `MODE_ASYNC_PERIPH);

   ////////////////////////////////////////////////////////////////////////////
   // internal clock generator for asynchronous peripheral mode
   // free running, so a write lands at any phase of its period
   reg [7:0] div_count;
   wire int_rise;
   wire int_fall;

   assign int_rise = (div_count == 8'h00);
   assign int_fall = (div_count == CONFIG_CLOCK_DIV[8:1]);

   always @(posedge CLK) begin
      if (SRST) begin
         div_count <= 8'h00;
      end else if (div_count == CONFIG_CLOCK_DIV[7:0] - 8'h01) begin
         div_count <= 8'h00;
      end else begin
         div_count <= div_count + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronous peripheral capture
   reg started;
   reg [2:0] edge_count;
   reg ack;
   wire sync_capture;

   // the edge counter restarts whenever mode or init drop, so a new frame starts clean
   // first edge after init takes a byte, then every eighth edge
   assign sync_capture = sync_mode && init_high && config_clock_rise &&
      (!started || edge_count == `BYTE_EDGE_LAST);

   always @(posedge CLK) begin
      if (SRST) begin
         started <= 1'b0;
         edge_count <= 3'h0;
         ack <= 1'b0;
      end else if (!sync_mode || !init_high) begin
         started <= 1'b0;
         edge_count <= 3'h0;
         ack <= 1'b0;
      end else if (config_clock_rise) begin
         if (sync_capture) begin
            started <= 1'b1;
            edge_count <= 3'h0;
         end else begin
            edge_count <= edge_count + 3'h1;
         end
         // high from the capturing edge to the next rising edge
         ack <= sync_capture;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous peripheral write
   reg write_open;
   reg busy;
   reg [3:0] busy_ticks;
   reg [7:0] write_byte;
   reg write_load;
   wire async_capture;

   // a falling strobe while busy is ignored; the write must start again
   // the byte is caught no later than the trailing strobe edge
   assign async_capture = async_mode && init_high && write_open && strobe_rise;

   always @(posedge CLK) begin
      if (SRST) begin
         write_open <= 1'b0;
         write_load <= 1'b0;
      end else begin
         write_load <= 1'b0;
         if (!async_mode || !init_high) begin
            write_open <= 1'b0;
         end else if (strobe_fall && !busy) begin
            write_open <= 1'b1;
         end else if (async_capture) begin
            write_open <= 1'b0;
            write_load <= 1'b1;
         end
      end
   end

   // track the bus while the strobe is low, so no data hold is needed after its trailing edge
   always @(posedge CLK) begin
      if (SRST) begin
         write_byte <= 8'h00;
      end else if (write_open && !strobe_sync[1]) begin
         write_byte <= data_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // converter shared by both modes
   // hold and shift registers give the double buffer
   wire ser_load;
   wire [7:0] ser_byte;
   wire shift_tick;
   wire fall_tick;
   wire hold_full;
   wire shift_busy;

   assign ser_load = sync_capture || write_load;
   assign ser_byte = sync_capture ? data_sync : write_byte;
   // slave mode follows the supplied clock, asynchronous mode the divider
   assign shift_tick = sync_mode ? config_clock_rise : (async_mode && int_rise);
   assign fall_tick = sync_mode ? config_clock_fall : (async_mode && int_fall);

   cfg_serializer #(
      .PREAMBLE_BITS(PREAMBLE_BITS),
      .OWN_BITS(OWN_BITS),
      .COUNT_W(COUNT_W)
   ) u_serializer (
      .clk(CLK),
      .srst(SRST),
      .load(ser_load),
      .load_byte(ser_byte),
      .shift_tick(shift_tick),
      .fall_tick(fall_tick),
      .hold_full(hold_full),
      .shift_busy(shift_busy),
      .serial_out(CHAIN_OUT)
   );

   ////////////////////////////////////////////////////////////////////////////
   // busy interval: at least the minimum, then until the input register drains
   // the longest case is a byte waiting in the hold register for a full shift
   always @(posedge CLK) begin
      if (SRST) begin
         busy <= 1'b0;
         busy_ticks <= 4'h0;
      end else if (!async_mode || !init_high) begin
         busy <= 1'b0;
         busy_ticks <= 4'h0;
      end else if (write_load) begin
         busy <= 1'b1;
         busy_ticks <= 4'h0;
      end else if (busy && int_rise) begin
         if (busy_ticks != `BUSY_MAX_TICKS) begin
            busy_ticks <= busy_ticks + 4'h1;
         end
         // empty converter frees after the minimum, a full one waits for the shift
         // the first tick may follow the load by one cycle, so release waits for the next full ones
         if (busy_ticks >= `BUSY_MIN_TICKS && !hold_full) begin
            busy <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // handshake pin drive
   // sync mode shows the acknowledge pulse, async mode shows ready when high
   always @(posedge CLK) begin
      if (SRST) begin
         READY_BUSY_OUT <= 1'b0;
         READY_BUSY_OE <= 1'b0;
      end else if (!init_high) begin
         // left to the pull-up before init
         READY_BUSY_OUT <= 1'b0;
         READY_BUSY_OE <= 1'b0;
      end else if (sync_mode) begin
         READY_BUSY_OUT <= ack;
         READY_BUSY_OE <= 1'b1;
      end else if (async_mode) begin
         READY_BUSY_OUT <= !busy;
         READY_BUSY_OE <= 1'b1;
      end else begin
         READY_BUSY_OUT <= 1'b0;
         READY_BUSY_OE <= 1'b0;
      end
   end

endmodule

// [cfg_loader_assertions.sv]
// assertion checker for the configuration loader ports
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"
module cfg_loader_checker (
   // watched ports
   input wire CLK,
   input wire SRST,
   input wire CONFIG_CLOCK,
   input wire MODE_SELECT_HIGH,
   input wire MODE_SELECT_MID,
   input wire MODE_SELECT_LOW,
   input wire INIT,
   input wire WRITE_STROBE_N,
   input wire READY_BUSY_OUT,
   input wire READY_BUSY_OE,
   input wire CHAIN_OUT
);
   wire [2:0] mode = {MODE_SELECT_HIGH, MODE_SELECT_MID, MODE_SELECT_LOW};
   wire syn = INIT && mode == `MODE_SYNC_PERIPH;
   wire asy = INIT && mode == `MODE_ASYNC_PERIPH;
   // recent configuration clock samples
   reg [7:0] h;
   always @(posedge CLK) h <= {h[6:0], CONFIG_CLOCK};
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_write;
      !WRITE_STROBE_N && READY_BUSY_OUT && asy ##1 $rose(WRITE_STROBE_N);
   endsequence
   sequence s_busy;
      $fell(READY_BUSY_OUT) && asy;
   endsequence
   sequence s_ack;
      $rose(READY_BUSY_OUT) && syn;
   endsequence
   ////////////////////////////////////////
   AST_NO_INIT: assert property (!INIT [*4] |-> !READY_BUSY_OE)
      else $error("pin driven early");
   AST_MODE_ON: assert property (syn [*5] |-> READY_BUSY_OE)
      else $error("pin undriven");
   AST_ACK_EDGE: assert property (s_ack |-> !h[7] && h[1])
      else $error("ack off rise");
   AST_ACK_LEN: assert property (s_ack |-> READY_BUSY_OUT [*8] ##1 !READY_BUSY_OUT)
      else $error("ack length");
   AST_CHAIN_FALL: assert property (syn && $changed(CHAIN_OUT) |-> h[6] && !h[1])
      else $error("chain off fall");
   AST_BUSY_MIN: assert property (s_busy |-> !READY_BUSY_OUT [*8] ##1 !READY_BUSY_OUT [*8])
      else $error("busy short");
   AST_BUSY_MAX: assert property (s_busy |-> ##[1:72] READY_BUSY_OUT)
      else $error("busy long");
   AST_WRITE_TAKEN: assert property (s_write |-> ##[1:8] !READY_BUSY_OUT)
      else $error("write not taken");
endmodule
bind cfg_loader cfg_loader_checker chk (.CLK(CLK), .SRST(SRST), .CONFIG_CLOCK(CONFIG_CLOCK),
   .MODE_SELECT_HIGH(MODE_SELECT_HIGH), .MODE_SELECT_MID(MODE_SELECT_MID), .MODE_SELECT_LOW(MODE_SELECT_LOW),
   .INIT(INIT), .WRITE_STROBE_N(WRITE_STROBE_N), .READY_BUSY_OUT(READY_BUSY_OUT),
   .READY_BUSY_OE(READY_BUSY_OE), .CHAIN_OUT(CHAIN_OUT));

// [cfg_host.sv]
// configuration controller model: clock, bytes and write strobe
`timescale 1ns/1ps
module cfg_host (
   // system clock
   input wire clk,
   // pins toward the device
   output reg config_clock = 1'b0,
   output reg [7:0] data = 8'h00,
   output reg strobe_n = 1'b1
);
   reg [7:0] q[$];
   integer i;
   task half(input v);
      begin
         repeat (4) @(posedge clk);
         #1 config_clock = v;
      end
   endtask
   // clock stands still outside frames; caller raises init first
   task run;
      begin
         data = q[0];
         for (i = 0; i < 8 * q.size() + 4; i = i + 1) begin
            half(1'b1);
            half(1'b0);
            if (i % 8 == 7) data = (i / 8 + 1 < q.size()) ? q[i / 8 + 1] : ~data;
         end
      end
   endtask
   task write(input [7:0] b);
      begin
         @(posedge clk);
         #1 strobe_n = 1'b0;
         data = b;
         repeat (9) @(posedge clk);
         #1 strobe_n = 1'b1;
         data = ~b;
      end
   endtask
endmodule

// [cfg_loader_test.sv]
// self-checking bench for the configuration loader
`timescale 1ns/1ps
module cfg_loader_test;
   localparam P = 8, O = 8;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg init = 1'b1;
   reg mon = 1'b0;
   reg [2:0] mode = 3'h0;
   reg [31:0] seed = 32'h23;
   reg sb[$];
   reg aq[$];
   reg amon = 1'b0;
   reg [7:0] b0 = 8'h00;
   wire config_clock, strobe_n, rb_out, rb_oe, chain;
   wire [7:0] data;
   // pull-up on the handshake pin
   wire rb_pin = rb_oe ? rb_out : 1'b1;
   integer num_errors = 0, compares = 0, cyc = 0, rc = 0, nb = 0, k, i, j, t;
   integer lo[0:2];
   always #50 clk = ~clk;
   cfg_host ctl (.clk(clk), .config_clock(config_clock), .data(data), .strobe_n(strobe_n));
   cfg_loader #(.PREAMBLE_BITS(P), .OWN_BITS(O), .COUNT_W(20), .CONFIG_CLOCK_DIV(8)) uut (.CLK(clk), .SRST(srst),
      .CONFIG_CLOCK(config_clock), .MODE_SELECT_HIGH(mode[2]), .MODE_SELECT_MID(mode[1]), .MODE_SELECT_LOW(mode[0]),
      .INIT(init), .DATA(data), .WRITE_STROBE_N(strobe_n), .READY_BUSY_OUT(rb_out), .READY_BUSY_OE(rb_oe),
      .CHAIN_OUT(chain));
   function [31:0] xs(input [31:0] x);
      begin
         x = x ^ (x << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("errors %0d compares %0d", num_errors, compares);
         if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task step(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task busy_len(output integer n);
      begin
         n = 0;
         for (t = 0; t < 20 && rb_pin === 1'b1; t = t + 1) @(posedge clk) #2;
         while (rb_pin === 1'b0 && n < 100) begin
            @(posedge clk) #2;
            n = n + 1;
         end
      end
   endtask
   ////////////////////////////////////////
   always @(posedge config_clock) if (mon) begin
      k = rc;
      rc = rc + 1;
      #450 check({rb_oe, rb_pin}, {1'b1, k % 8 == 0});
   end
   always @(negedge config_clock) if (mon && rc >= 3 && rc - 3 < 8 * nb)
      check(chain, (rc - 3 < P || rc - 3 >= P + O) ? sb[rc - 3] : 1'b1);
   // async mode: chained output changes once per internal period, so one sample per period
   always @(posedge clk) if (amon && cyc % 8 == 0) #2 aq.push_back(chain);
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         test_done;
      end
   end
   initial begin
      step(10);
      srst = 1'b0;
      step(8);
      check({rb_oe, rb_pin}, 2'b01);
      mode = 3'h3;
      init = 1'b0;
      step(8);
      check({rb_oe, rb_pin}, 2'b01);
      init = 1'b1;
      step(8);
      check(rb_oe, 1'b1);
      for (j = 0; j < 32; j = j + 1) begin
         if (j % 8 == 0) begin
            seed = xs(seed);
            ctl.q.push_back(seed[7:0]);
         end
         sb.push_back(seed[j % 8]);
      end
      nb = 4;
      mon = 1'b1;
      ctl.run;
      step(8);
      mon = 1'b0;
      srst = 1'b1;
      mode = 3'h5;
      step(10);
      srst = 1'b0;
      step(8);
      check(rb_pin, 1'b1);
      amon = 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         seed = xs(seed);
         if (i == 0) b0 = {seed[7:1], 1'b0};
         ctl.write(i == 0 ? b0 : seed[7:0]);
         busy_len(lo[i]);
         check(lo[i] >= 2 * 8 && lo[i] <= 9 * 8, 1);
      end
      amon = 1'b0;
      check(lo[1] > lo[0], 1);
      check(lo[2] > lo[0], 1);
      j = 0;
      while (j < aq.size() && aq[j] !== 1'b0) j = j + 1;
      for (i = 0; i < 8; i = i + 1) check(aq[j + i], b0[i]);
      test_done;
   end
endmodule
